// ### common/gain_bank_pkg.sv
// constants and types for the gain bank selection block
package gain_bank_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_GAIN_MODE    = 8'h00;
    localparam logic [7:0] ADDR_MODEL_CFG    = 8'h04;
    localparam logic [7:0] ADDR_COND_CFG     = 8'h08;
    localparam logic [7:0] ADDR_TIMING       = 8'h0c;
    localparam logic [7:0] ADDR_STATUS       = 8'h10;
    localparam logic [7:0] ADDR_BANK1_BASE   = 8'h20;
    localparam logic [7:0] ADDR_BANK2_BASE   = 8'h40;
    localparam logic [7:0] ADDR_BIAS_FWD     = 8'h60;
    localparam logic [7:0] ADDR_BIAS_REV     = 8'h64;
    localparam logic [7:0] ADDR_VIB_FREQ_A   = 8'h68;
    localparam logic [7:0] ADDR_VIB_FREQ_B   = 8'h6c;
    localparam logic [7:0] ADDR_SPEED_FF     = 8'h70;
    localparam logic [7:0] ADDR_FF_GAIN      = 8'h74;
    // field positions
    localparam int MODE_DIGIT_LSB = 0;
    localparam int MODEL_TOP_LSB  = 12;
    // digit encodings
    localparam logic [3:0] MODE_MANUAL = 4'h0;
    localparam logic [3:0] MODE_AUTO   = 4'h2;
    // reset values
    localparam logic [15:0] RST_GAIN_MODE = 16'h0000;
    localparam logic [15:0] RST_MODEL_CFG = 16'h0000;
    localparam logic [15:0] RST_COND_CFG  = 16'h0000;
    localparam logic [15:0] RST_WAIT      = 16'h0000;
    localparam logic [15:0] RST_RAMP      = 16'h0000;
    localparam logic [15:0] RST_PARAM     = 16'h0000;
    // bank values: 0 spd gain,1 spd integ,2 pos gain,3 force filt,
    // 4 model gain,5 model comp,6 friction gain
    localparam int NUM_VAL  = 7;
    localparam int IDX_MF_G = 4;
    localparam int IDX_MF_C = 5;
    // control cycle: one enable every CTRL_DIV system clocks
    localparam int CLK_NS        = 50;
    localparam int CTRL_CYCLE_NS = 1000;
    localparam int CTRL_DIV      = CTRL_CYCLE_NS / CLK_NS;
    // automatic switching walk
    typedef enum logic [1:0] {
        SW_IDLE = 2'b00,
        SW_WAIT = 2'b01,
        SW_RAMP = 2'b11
    } sw_state_t;
endpackage : gain_bank_pkg

// ### rtl/gain_ramp_lane.sv
// one output lane: holds a value and walks linearly to a target
`timescale 1ns/1ps
`default_nettype none
module gain_ramp_lane
    import gain_bank_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // control
    input  wire logic        load,
    input  wire logic        ramp_start,
    input  wire logic        step,
    input  wire logic [15:0] ramp_len,
    input  wire logic [15:0] target,
    // result
    output logic      [15:0] value_q
);
    logic [15:0] value_d;
    logic [15:0] start_q, start_d;
    logic [15:0] cnt_q, cnt_d;
    logic signed [16:0] span;
    logic signed [33:0] part;

    // linear blend: start + (target-start)*cnt/len; settings are unsigned
    // so the span is zero-extended, and the product keeps all 34 bits
    always_comb
    begin
        value_d = value_q;
        start_d = start_q;
        cnt_d   = cnt_q;
        span    = signed'({1'b0, target}) - signed'({1'b0, start_q});
        part    = '0;
        if (load)
        begin
            value_d = target;
            start_d = target;
            cnt_d   = 16'h0;
        end
        else if (ramp_start)
        begin
            start_d = value_q;
            cnt_d   = 16'h0;
        end
        else if (step && cnt_q < ramp_len)
        begin
            cnt_d = cnt_q + 16'h1;
            part  = span * $signed({1'b0, cnt_d})
                    / $signed({1'b0, ramp_len});
            value_d = 16'(start_q + part[15:0]);
        end
        else if (step)
        begin
            value_d = target;
        end
    end

    // state registers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            value_q <= RST_PARAM;
            start_q <= RST_PARAM;
            cnt_q   <= 16'h0;
        end
        else
        begin
            value_q <= value_d;
            start_q <= start_d;
            cnt_q   <= cnt_d;
        end
    end
endmodule // gain_ramp_lane
`default_nettype wire

// ### rtl/gain_bank_switch_select.sv
// gain bank selection with ahb-lite registers and automatic ramping
`timescale 1ns/1ps
`default_nettype none
module gain_bank_switch_select
    import gain_bank_pkg::*;
(
    // clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        RST_B,
    // ahb-lite slave
    input  wire logic        HSEL,
    input  wire logic [7:0]  HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    // motion state and host option bits
    input  wire logic        GAIN_SEL,
    input  wire logic        CMD_BUSY,
    input  wire logic        MOTOR_STOPPED,
    input  wire logic        POS_CONTROL,
    input  wire logic        POS_DONE,
    input  wire logic        POS_NEAR,
    input  wire logic        REF_ACTIVE,
    input  wire logic        FILTER_OUT,
    // tuning function
    input  wire logic        TUNE_BUSY,
    input  wire logic        TUNE_DONE,
    input  wire logic [15:0] TUNE_MODEL_CFG,
    input  wire logic [15:0] TUNE_MODEL_GAIN,
    input  wire logic [15:0] TUNE_FREQ_A,
    input  wire logic [15:0] TUNE_FREQ_B,
    // host feedforward
    input  wire logic [15:0] HOST_SPEED_FF,
    input  wire logic [15:0] HOST_FORCE_FF,
    // selected values
    output logic      [15:0] SPEED_GAIN,
    output logic      [15:0] SPEED_INTEG,
    output logic      [15:0] POS_GAIN,
    output logic      [15:0] FORCE_FILT,
    output logic      [15:0] MODEL_GAIN,
    output logic      [15:0] MODEL_COMP,
    output logic      [15:0] FRICTION_GAIN,
    output logic      [15:0] SPEED_FF_OUT,
    output logic      [15:0] FORCE_FF_OUT,
    output logic      [15:0] FF_GAIN_OUT,
    output logic             BANK2_ACTIVE
);
    // reset release through two flops
    logic rst_s1_q, rst_n;
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
        begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    // registers
    logic [15:0] mode_q, mode_d, model_q, model_d, cond_q, cond_d;
    logic [15:0] wait_q, wait_d, ramp_q, ramp_d;
    logic [15:0] bias_f_q, bias_f_d, bias_r_q, bias_r_d;
    logic [15:0] freq_a_q, freq_a_d, freq_b_q, freq_b_d;
    logic [15:0] sff_q, sff_d, ffg_q, ffg_d;
    logic [15:0] bank1_q [NUM_VAL];
    logic [15:0] bank1_d [NUM_VAL];
    logic [15:0] bank2_q [NUM_VAL];
    logic [15:0] bank2_d [NUM_VAL];

    // ahb address phase capture; slave is always ready
    logic       wr_pend_q, wr_pend_d;
    logic [7:0] addr_q, addr_d;
    logic [31:0] rdata_d;
    logic       take;
    assign take = HSEL && HREADY && HTRANS[1];

    // lock only covers parameters the tuning function reads
    logic locked;
    assign locked = TUNE_BUSY;

    always_comb
    begin
        wr_pend_d = take && HWRITE;
        addr_d    = take ? HADDR : addr_q;
        mode_d = mode_q;
        model_d = model_q;
        cond_d = cond_q;
        wait_d = wait_q;
        ramp_d = ramp_q;
        bias_f_d = bias_f_q;
        bias_r_d = bias_r_q;
        freq_a_d = freq_a_q;
        freq_b_d = freq_b_q;
        sff_d = sff_q;
        ffg_d = ffg_q;
        bank1_d = bank1_q;
        bank2_d = bank2_q;
        if (wr_pend_q)
        begin
            if (addr_q == ADDR_GAIN_MODE)
                mode_d = HWDATA[15:0];
            else if (addr_q == ADDR_MODEL_CFG)
                model_d = HWDATA[15:0];
            else if (addr_q == ADDR_COND_CFG)
                cond_d = HWDATA[15:0];
            else if (addr_q == ADDR_TIMING)
            begin
                wait_d = HWDATA[15:0];
                ramp_d = HWDATA[31:16];
            end
            else if (addr_q == ADDR_BIAS_FWD && !locked)
                bias_f_d = HWDATA[15:0];
            else if (addr_q == ADDR_BIAS_REV && !locked)
                bias_r_d = HWDATA[15:0];
            else if (addr_q == ADDR_VIB_FREQ_A && !locked)
                freq_a_d = HWDATA[15:0];
            else if (addr_q == ADDR_VIB_FREQ_B && !locked)
                freq_b_d = HWDATA[15:0];
            else if (addr_q == ADDR_SPEED_FF && !locked)
                sff_d = HWDATA[15:0];
            else if (addr_q == ADDR_FF_GAIN)
                ffg_d = HWDATA[15:0];
            else if (addr_q[7:5] == ADDR_BANK1_BASE[7:5]
                     && addr_q[4:2] < 3'(NUM_VAL))
            begin
                if (!(locked && (addr_q[4:2] == 3'(IDX_MF_G)
                      || addr_q[4:2] == 3'(IDX_MF_C))))
                    bank1_d[addr_q[4:2]] = HWDATA[15:0];
            end
            else if (addr_q[7:5] == ADDR_BANK2_BASE[7:5]
                     && addr_q[4:2] < 3'(NUM_VAL))
            begin
                if (!(locked && (addr_q[4:2] == 3'(IDX_MF_G)
                      || addr_q[4:2] == 3'(IDX_MF_C))))
                    bank2_d[addr_q[4:2]] = HWDATA[15:0];
            end
        end
        // tuning result lands after any software write
        if (TUNE_DONE)
        begin
            model_d = TUNE_MODEL_CFG;
            bank1_d[IDX_MF_G] = TUNE_MODEL_GAIN;
            freq_a_d = TUNE_FREQ_A;
            freq_b_d = TUNE_FREQ_B;
        end
    end

    // read mux, decoded from the address phase
    logic [31:0] sel_status;
    always_comb
    begin
        rdata_d = 32'h0;
        if (!take || HWRITE)
            rdata_d = 32'h0;
        else if (HADDR == ADDR_GAIN_MODE)
            rdata_d = {16'h0, mode_q};
        else if (HADDR == ADDR_MODEL_CFG)
            rdata_d = {16'h0, model_q};
        else if (HADDR == ADDR_COND_CFG)
            rdata_d = {16'h0, cond_q};
        else if (HADDR == ADDR_TIMING)
            rdata_d = {ramp_q, wait_q};
        else if (HADDR == ADDR_STATUS)
            rdata_d = sel_status;
        else if (HADDR == ADDR_BIAS_FWD)
            rdata_d = {16'h0, bias_f_q};
        else if (HADDR == ADDR_BIAS_REV)
            rdata_d = {16'h0, bias_r_q};
        else if (HADDR == ADDR_VIB_FREQ_A)
            rdata_d = {16'h0, freq_a_q};
        else if (HADDR == ADDR_VIB_FREQ_B)
            rdata_d = {16'h0, freq_b_q};
        else if (HADDR == ADDR_SPEED_FF)
            rdata_d = {16'h0, sff_q};
        else if (HADDR == ADDR_FF_GAIN)
            rdata_d = {16'h0, ffg_q};
        else if (HADDR[7:5] == ADDR_BANK1_BASE[7:5]
                 && HADDR[4:2] < 3'(NUM_VAL))
            rdata_d = {16'h0, bank1_q[HADDR[4:2]]};
        else if (HADDR[7:5] == ADDR_BANK2_BASE[7:5]
                 && HADDR[4:2] < 3'(NUM_VAL))
            rdata_d = {16'h0, bank2_q[HADDR[4:2]]};
    end

    // register file storage
    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_pend_q <= 1'b0;
            addr_q    <= 8'h0;
            HRDATA    <= 32'h0;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
            mode_q    <= RST_GAIN_MODE;
            model_q   <= RST_MODEL_CFG;
            cond_q    <= RST_COND_CFG;
            wait_q    <= RST_WAIT;
            ramp_q    <= RST_RAMP;
            bias_f_q  <= RST_PARAM;
            bias_r_q  <= RST_PARAM;
            freq_a_q  <= RST_PARAM;
            freq_b_q  <= RST_PARAM;
            sff_q     <= RST_PARAM;
            ffg_q     <= RST_PARAM;
            for (int i = 0; i < NUM_VAL; i++)
            begin
                bank1_q[i] <= RST_PARAM;
                bank2_q[i] <= RST_PARAM;
            end
        end
        else
        begin
            wr_pend_q <= wr_pend_d;
            addr_q    <= addr_d;
            HRDATA    <= rdata_d;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
            mode_q    <= mode_d;
            model_q   <= model_d;
            cond_q    <= cond_d;
            wait_q    <= wait_d;
            ramp_q    <= ramp_d;
            bias_f_q  <= bias_f_d;
            bias_r_q  <= bias_r_d;
            freq_a_q  <= freq_a_d;
            freq_b_q  <= freq_b_d;
            sff_q     <= sff_d;
            ffg_q     <= ffg_d;
            bank1_q   <= bank1_d;
            bank2_q   <= bank2_d;
        end
    end

    // control cycle divider and bank decision
    logic [7:0] div_q, div_d;
    logic       tick;
    logic       auto_mode, cond_a, want2;
    logic       bank_q, bank_d, mf_bank_q, mf_bank_d;
    logic [15:0] wcnt_q, wcnt_d;
    sw_state_t  st_q, st_d;
    logic       ld, rstart;
    assign tick      = (div_q == 8'(CTRL_DIV - 1));
    assign auto_mode = (mode_q[MODE_DIGIT_LSB+:4] == MODE_AUTO);
    assign sel_status = {28'h0, st_q, mf_bank_q, bank_q};

    // condition a and the fixed bank outside position control
    always_comb
    begin
        case (cond_q[7:4])
            4'h0: cond_a = POS_DONE;
            4'h1: cond_a = !POS_DONE;
            4'h2: cond_a = POS_NEAR;
            4'h3: cond_a = !POS_NEAR;
            4'h4: cond_a = !FILTER_OUT && !REF_ACTIVE;
            default: cond_a = REF_ACTIVE;
        endcase
        if (auto_mode)
            want2 = POS_CONTROL ? cond_a : cond_q[4];
        else
            want2 = GAIN_SEL;
    end

    always_comb
    begin
        div_d     = tick ? 8'h0 : div_q + 8'h1;
        bank_d    = bank_q;
        mf_bank_d = mf_bank_q;
        st_d      = st_q;
        wcnt_d    = wcnt_q;
        ld        = 1'b0;
        rstart    = 1'b0;
        if (tick)
        begin
            case (st_q)
                SW_IDLE:
                begin
                    if (want2 != bank_q && auto_mode)
                    begin
                        bank_d = want2;
                        wcnt_d = 16'h0;
                        st_d   = SW_WAIT;
                    end
                    else if (want2 != bank_q)
                    begin
                        bank_d = want2;
                        ld     = 1'b1;
                    end
                    if (!auto_mode && mf_bank_q != want2
                        && !CMD_BUSY && MOTOR_STOPPED)
                    begin
                        mf_bank_d = want2;
                        ld        = 1'b1;
                    end
                end
                SW_WAIT:
                begin
                    wcnt_d = wcnt_q + 16'h1;
                    if (wcnt_q >= wait_q)
                    begin
                        rstart = 1'b1;
                        st_d   = SW_RAMP;
                    end
                end
                default:
                begin
                    wcnt_d = wcnt_q + 16'h1;
                    if (wcnt_q >= 16'(wait_q + ramp_q))
                        st_d = SW_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_q     <= 8'h0;
            bank_q    <= 1'b0;
            mf_bank_q <= 1'b0;
            st_q      <= SW_IDLE;
            wcnt_q    <= 16'h0;
        end
        else
        begin
            div_q     <= div_d;
            bank_q    <= bank_d;
            mf_bank_q <= mf_bank_d;
            st_q      <= st_d;
            wcnt_q    <= wcnt_d;
        end
    end

    // one lane per value; model lanes follow their own bank
    // every lane reloads while idle, so a settings write acts at once
    logic [15:0] lane_val [NUM_VAL];
    generate
        for (genvar g = 0; g < NUM_VAL; g++)
        begin : g_lane
            localparam bit MF = (g == IDX_MF_G) || (g == IDX_MF_C);
            logic b;
            assign b = MF ? mf_bank_q : bank_q;
            gain_ramp_lane u_lane (
                .clk        (CLK_SYS),
                .rst_n      (rst_n),
                .load       (ld || st_q == SW_IDLE),
                .ramp_start (rstart && !MF),
                .step       (tick && st_q == SW_RAMP),
                .ramp_len   (ramp_q),
                .target     (b ? bank2_q[g] : bank1_q[g]),
                .value_q    (lane_val[g])
            );
        end
    endgenerate

    // output stage; feedforward only passes when combination enabled
    logic ff_on;
    assign ff_on = model_q[MODEL_TOP_LSB+:4] == 4'h1;
    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            SPEED_GAIN <= 16'h0;
            SPEED_INTEG <= 16'h0;
            POS_GAIN <= 16'h0;
            FORCE_FILT <= 16'h0;
            MODEL_GAIN <= 16'h0;
            MODEL_COMP <= 16'h0;
            FRICTION_GAIN <= 16'h0;
            SPEED_FF_OUT <= 16'h0;
            FORCE_FF_OUT <= 16'h0;
            FF_GAIN_OUT <= 16'h0;
            BANK2_ACTIVE <= 1'b0;
        end
        else
        begin
            SPEED_GAIN <= lane_val[0];
            SPEED_INTEG <= lane_val[1];
            POS_GAIN <= lane_val[2];
            FORCE_FILT <= lane_val[3];
            MODEL_GAIN <= lane_val[IDX_MF_G];
            MODEL_COMP <= lane_val[IDX_MF_C];
            FRICTION_GAIN <= lane_val[6];
            SPEED_FF_OUT <= ff_on ? HOST_SPEED_FF : 16'h0;
            FORCE_FF_OUT <= ff_on ? HOST_FORCE_FF : 16'h0;
            FF_GAIN_OUT <= ff_on ? ffg_q : 16'h0;
            BANK2_ACTIVE <= bank_q;
        end
    end

    // checks: one clock domain, silent while the synchronised reset holds
    default clocking cb_sys @(posedge CLK_SYS);
    endclocking
    default disable iff (!rst_n);

    // a manual request for the other model bank, seen at a tick
    sequence s_mf_request;
        tick && !auto_mode && st_q == SW_IDLE && mf_bank_q != want2;
    endsequence
    // no command executing and the motor standing still
    sequence s_mf_idle;
        !CMD_BUSY && MOTOR_STOPPED;
    endsequence

    a_ff_gated: assert property (
        !ff_on |=> SPEED_FF_OUT == 16'h0 && FORCE_FF_OUT == 16'h0)
        else $error("feedforward passed while disabled");
    a_ff_passed: assert property (
        ff_on |=> SPEED_FF_OUT == $past(HOST_SPEED_FF))
        else $error("feedforward not passed when enabled");
    a_bank_on_tick: assert property (
        $changed(bank_q) |-> $past(tick))
        else $error("bank changed off a control boundary");
    a_manual_follow: assert property (
        tick && !auto_mode && st_q == SW_IDLE |=> bank_q == $past(GAIN_SEL))
        else $error("manual bank does not follow select");
    a_mf_idle_only: assert property (
        $changed(mf_bank_q) |-> !$past(CMD_BUSY) && $past(MOTOR_STOPPED))
        else $error("model bank changed while moving");
    a_mf_switch: assert property (
        s_mf_request ##0 s_mf_idle |=> mf_bank_q == $past(want2))
        else $error("model bank did not switch while idle");
    a_mf_auto_hold: assert property (
        auto_mode && $past(auto_mode) |-> $stable(mf_bank_q))
        else $error("model bank changed in automatic mode");
    a_lock_writes: assert property (
        locked && !TUNE_DONE |=> $stable(bias_f_q) && $stable(freq_a_q))
        else $error("locked parameter written during tuning");
    a_tune_load: assert property (
        TUNE_DONE |=> model_q == $past(TUNE_MODEL_CFG)
                      && freq_b_q == $past(TUNE_FREQ_B))
        else $error("tuning result not loaded");
    a_auto_fixed: assert property (
        tick && auto_mode && !POS_CONTROL && st_q == SW_IDLE
        |=> bank_q == $past(cond_q[4]))
        else $error("fixed bank wrong outside position control");
endmodule // gain_bank_switch_select
`default_nettype wire

// ### tb/host_model.sv
// host motion controller model: option bit, motion state, feedforward
`timescale 1ns/1ps
`default_nettype none
module host_model
(
    // clock
    input  wire logic        clk,
    // bench requests
    input  wire logic        want_bank2,
    input  wire logic        moving,
    input  wire logic [15:0] ff_val,
    // host signals
    output logic             gain_sel,
    output logic             cmd_busy,
    output logic             stopped,
    output logic      [15:0] speed_ff,
    output logic      [15:0] force_ff
);
    // changes land just after the edge, as a real controller would;
    // outputs are unknown until the first edge, inside the reset time
    always @(posedge clk)
    begin
        gain_sel <= want_bank2;
        cmd_busy <= moving;
        stopped  <= !moving;
        speed_ff <= ff_val;
        force_ff <= ~ff_val;
    end
endmodule // host_model
`default_nettype wire

// ### tb/gain_bank_switch_select_tb.sv
// self-checking bench for the gain bank selection block
`timescale 1ns/1ps
`default_nettype none
module gain_bank_switch_select_tb;
    import gain_bank_pkg::*;
    logic        clk, rst_b, hsel, hwrite, hreadyout, hresp;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, r;
    logic        want2, moving, pos_ctl, tbusy, tdone, b5, bm;
    logic        gsel, cbusy, stopped, bank2;
    logic [3:0]  cnd;
    logic [15:0] ff_val, sff, fff, sffo, fffo, ffgo, lf;
    logic [15:0] out [7];
    logic [15:0] tv [4];
    int          b1 [7];
    int          b2 [7];
    int          fail_count, samples_checked, cyc;

    host_model host_u (.clk(clk), .want_bank2(want2), .moving(moving),
        .ff_val(ff_val), .gain_sel(gsel), .cmd_busy(cbusy),
        .stopped(stopped), .speed_ff(sff), .force_ff(fff));

    gain_bank_switch_select dut_u (.CLK_SYS(clk), .RST_B(rst_b),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
        .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
        .GAIN_SEL(gsel), .CMD_BUSY(cbusy), .MOTOR_STOPPED(stopped),
        .POS_CONTROL(pos_ctl), .POS_DONE(cnd[0]), .POS_NEAR(cnd[1]),
        .REF_ACTIVE(cnd[2]), .FILTER_OUT(cnd[3]), .TUNE_BUSY(tbusy),
        .TUNE_DONE(tdone), .TUNE_MODEL_CFG(tv[0]),
        .TUNE_MODEL_GAIN(tv[1]), .TUNE_FREQ_A(tv[2]),
        .TUNE_FREQ_B(tv[3]), .HOST_SPEED_FF(sff), .HOST_FORCE_FF(fff),
        .SPEED_GAIN(out[0]), .SPEED_INTEG(out[1]), .POS_GAIN(out[2]),
        .FORCE_FILT(out[3]), .MODEL_GAIN(out[4]), .MODEL_COMP(out[5]),
        .FRICTION_GAIN(out[6]), .SPEED_FF_OUT(sffo),
        .FORCE_FF_OUT(fffo), .FF_GAIN_OUT(ffgo), .BANK2_ACTIVE(bank2));

    // random source for register contents and host inputs
    function automatic logic [15:0] nxt(logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    // one single ahb-lite transfer; waits on ready, never a fixed count
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'b010;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        r = hrdata;
    endtask

    task automatic rd(string n, logic [7:0] a, logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(n, r, e);
    endtask

    // five control ticks cover tick wait, switch wait, ramp and latency
    task automatic cmp_out;
        repeat (100) @(posedge clk);
        for (int i = 0; i < 7; i++)
            chk("value", out[i],
                ((i == 4 || i == 5) ? bm : b5) ? b2[i] : b1[i]);
        chk("bank2", bank2, b5);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // hang guard far beyond the roughly 1300 cycles the run needs
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            final_report();
        end
    end

    initial
    begin
        {rst_b, hsel, hwrite, htrans, haddr, hsize, hwdata} = '0;
        {want2, moving, pos_ctl, tbusy, tdone, cnd, b5, bm} = '0;
        ff_val = 16'h0000;
        lf = 16'h0028;
        for (int i = 0; i < 4; i++) tv[i] = 16'h0000;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        lf = nxt(lf);
        ff_val <= lf;
        rd("mode", ADDR_GAIN_MODE, 32'h0);
        rd("model", ADDR_MODEL_CFG, 32'h0);
        rd("unmapped", 8'hfc, 32'h0);
        chk("spd ff off", {16'h0, sffo}, 32'h0);
        chk("frc ff off", {16'h0, fffo}, 32'h0);
        chk("ff gain off", {16'h0, ffgo}, 32'h0);
        chk("resp", {31'h0, hresp}, 32'h0);
        for (int i = 0; i < 7; i++)
        begin
            lf = nxt(lf);
            b1[i] = lf;
            bus(1'b1, ADDR_BANK1_BASE + 8'(4 * i), {16'h0, lf});
            lf = nxt(lf);
            b2[i] = lf;
            bus(1'b1, ADDR_BANK2_BASE + 8'(4 * i), {16'h0, lf});
        end
        bus(1'b1, ADDR_FF_GAIN, {16'h0, lf});
        cmp_out();
        // manual request while idle moves all seven
        want2 <= 1'b1;
        {b5, bm} = 2'b11;
        cmp_out();
        // request during motion: model values hold
        moving <= 1'b1;
        want2 <= 1'b0;
        b5 = 1'b0;
        cmp_out();
        moving <= 1'b0;
        bm = 1'b0;
        cmp_out();
        bus(1'b1, ADDR_MODEL_CFG, 32'h1000);
        repeat (60) @(posedge clk);
        chk("spd ff on", {16'h0, sffo}, {16'h0, ff_val});
        chk("frc ff on", {16'h0, fffo}, {16'h0, ~ff_val});
        chk("ff gain on", {16'h0, ffgo}, {16'h0, lf});
        // tuning running: bias and model gain locked, model config still writable
        tbusy <= 1'b1;
        bus(1'b1, ADDR_BIAS_FWD, 32'h55);
        bus(1'b1, ADDR_BANK1_BASE + 8'h10, 32'h77);
        bus(1'b1, ADDR_MODEL_CFG, 32'h0);
        rd("bias", ADDR_BIAS_FWD, 32'h0);
        rd("mf gain", ADDR_BANK1_BASE + 8'h10, b1[4]);
        rd("model", ADDR_MODEL_CFG, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            lf = nxt(lf);
            tv[i] <= lf;
        end
        tdone <= 1'b1;
        @(posedge clk);
        tdone <= 1'b0;
        tbusy <= 1'b0;
        b1[4] = tv[1];
        rd("t cfg", ADDR_MODEL_CFG, tv[0]);
        rd("t gain", ADDR_BANK1_BASE + 8'h10, tv[1]);
        rd("t fa", ADDR_VIB_FREQ_A, tv[2]);
        rd("t fb", ADDR_VIB_FREQ_B, tv[3]);
        rd("t bias", ADDR_BIAS_FWD, 32'h0);
        // automatic outside position control: fixed bank from condition
        // one tick of wait and one tick of ramp, so the ramp path runs
        bus(1'b1, ADDR_TIMING, 32'h0001_0001);
        bus(1'b1, ADDR_COND_CFG, 32'h10);
        bus(1'b1, ADDR_GAIN_MODE, 32'h2); // digit 2 selects automatic switching
        want2 <= 1'b1;
        b5 = 1'b1;
        cmp_out();
        // position control: condition codes 0 to 5 against random status
        pos_ctl <= 1'b1;
        for (int k = 0; k < 6; k++)
        begin
            lf = nxt(lf);
            bus(1'b1, ADDR_COND_CFG, 32'(k) << 4);
            cnd <= lf[3:0];
            b5 = (k == 0) ? lf[0] : (k == 1) ? !lf[0] : (k == 2) ? lf[1]
                : (k == 3) ? !lf[1] : (k == 4) ? !lf[3] && !lf[2] : lf[2];
            cmp_out();
        end
        rd("mode", ADDR_GAIN_MODE, 32'h2);
        final_report();
    end
endmodule // gain_bank_switch_select_tb
`default_nettype wire
